// >>> verilog/rsc_pkg.sv
// Purpose: constants and types of the regulator supervision control block
// Assumes: 8-bit register port, 100 MHz reference clock
// Notes:   analog comparators deliver plain levels, sampled by the block
// What this block does
// - overtemp warning with reduction option set forces converter output down to 5 V.
// - reduction option is zero after power-up and cleared by an external reset pin pulse.
// - overtemp warning flag reads one while chip temperature exceeds the warning threshold.
// - main regulator watched always; below chosen threshold raises system reset.
// - threshold field bits 1:0 pick 90, 80, 70 or 60 percent.
// - 3.3 V variant always uses 90 percent, ignoring field and start-up bits.
// - threshold field loaded from non-volatile start-up bits at power-up.
// - main undervoltage interrupt below 90 percent, only while its enable is one.
// - main supply status bit tells above or below 90 percent.
// - pass transistor off during external output overvoltage, back on afterwards.
// - aux control bits 3:2: off, Normal, plus Standby/Reset, plus Sleep/fail-safe.
// - aux control field loaded from non-volatile start-up bits at power-up.
// - external output low interrupt below 90, high interrupt at 110 percent.
// - external output condition readable in supply status register.
// - shutdown response bits 5:4 choose battery faults that turn aux off.
package rsc_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  REG_CTRL_ADDR  = 8'h10;
  localparam logic [7:0]  REG_STAT_ADDR  = 8'h11;
  localparam logic [7:0]  REG_IRQ_ADDR   = 8'h12;
  localparam logic [7:0]  REG_MASK_ADDR  = 8'h13;
  localparam logic [7:0]  REG_CONV_ADDR  = 8'h14;
  // control field positions
  localparam int          THR_LSB        = 0;
  localparam int          AUX_LSB        = 2;
  localparam int          SHUT_LSB       = 4;
  localparam logic [5:0]  CTRL_RESET     = 6'h00;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;
  localparam logic [3:0]  MASK_RESET     = 4'h0;
  // interrupt bit positions
  localparam int          IRQ_MAIN_UV    = 0;
  localparam int          IRQ_EXT_LOW    = 1;
  localparam int          IRQ_EXT_HIGH   = 2;
  localparam int          IRQ_OVERTEMP   = 3;
  // synchroniser vector positions
  localparam int          SY_MAIN        = 0;
  localparam int          SY_OT          = 4;
  localparam int          SY_EXT_LOW     = 5;
  localparam int          SY_EXT_HIGH    = 6;
  localparam int          SY_EXT_OV      = 7;
  localparam int          SY_BAT_UV      = 8;
  localparam int          SY_BAT_OV      = 9;
  localparam int          SY_PIN_N       = 10;
  localparam int          SY_V3V3        = 11;
  localparam int          SY_THR_SU      = 12;
  localparam int          SY_AUX_SU      = 14;
  localparam int          SY_W           = 16;
  localparam logic [15:0] SYNC_RESET     = 16'h0400;
  localparam logic [1:0]  INIT_LOAD      = 2'h2;
  localparam logic [1:0]  INIT_DONE      = 2'h3;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_RESET,
    MODE_SLEEP,
    MODE_FAILSAFE
  } rsc_mode_type;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic [1:0]      init_cnt;
    logic [5:0]      ctrl;
    logic            reduce_en;
    logic [3:0]      irq_stat;
    logic [3:0]      irq_mask;
    logic            conv_5v;
    logic            sys_rst;
    logic            aux_en;
    logic            pass_en;
    logic            irq;
    logic [7:0]      rd_data;
  } rsc_state_type;
endpackage

// >>> verilog/rsc_regulator_supervision.sv
// Purpose: supervision and control of the converter and both linear regulators
// Assumes: comparator levels and straps are asynchronous; op mode is on i_ref_clk
// Notes:   every comparator path is two sync stages plus one output stage
`timescale 1ns/100ps
`default_nettype none
module rsc_regulator_supervision
  import rsc_pkg::*;
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [7:0]   i_addr,
  input  wire logic [7:0]   i_wr_data,
  input  wire logic         i_wr_stb,
  input  wire logic         i_rd_stb,
  output logic [7:0]        o_rd_data,
  input  wire logic [3:0]   i_main_below_lvl,
  input  wire logic         i_overtemp_warn,
  input  wire logic         i_ext_below_90,
  input  wire logic         i_ext_above_110,
  input  wire logic         i_ext_overvoltage,
  input  wire logic         i_bat_undervolt,
  input  wire logic         i_bat_overvolt,
  input  wire logic         i_external_reset_pin_n,
  input  wire logic         i_variant_3v3,
  input  wire logic [1:0]   i_main_threshold_startup_bits,
  input  wire logic [1:0]   i_aux_startup_bits,
  input  wire rsc_mode_type i_op_mode,
  output logic              o_conv_out_5v_sel,
  output logic              o_sys_reset,
  output logic              o_aux_reg_en,
  output logic              o_ext_pass_en,
  output logic              o_irq
);

  rsc_state_type   state_q;
  rsc_state_type   state_d;
  logic [SY_W-1:0] async_in;
  logic [1:0]      thr_sel;
  logic            aux_mode_on;
  logic            aux_fault;
  logic [3:0]      irq_event;
  logic [7:0]      status_rd;
  logic            wr_ctrl;
  logic            wr_irq;
  logic            wr_mask;
  logic            wr_conv;

  assign async_in = {i_aux_startup_bits, i_main_threshold_startup_bits, i_variant_3v3,
                     i_external_reset_pin_n, i_bat_overvolt, i_bat_undervolt,
                     i_ext_overvoltage, i_ext_above_110, i_ext_below_90,
                     i_overtemp_warn, i_main_below_lvl};

  assign wr_ctrl = i_wr_stb && (i_addr == REG_CTRL_ADDR);
  assign wr_irq  = i_wr_stb && (i_addr == REG_IRQ_ADDR);
  assign wr_mask = i_wr_stb && (i_addr == REG_MASK_ADDR);
  assign wr_conv = i_wr_stb && (i_addr == REG_CONV_ADDR);

  always_comb begin
    state_d = state_q;
    // first stage feeds only the second
    state_d.sync1 = async_in;
    state_d.sync2 = state_q.sync1;

    // start-up bits are valid once they have crossed both stages
    if (state_q.init_cnt != INIT_DONE) begin
      state_d.init_cnt = state_q.init_cnt + 2'h1;
    end
    if (state_q.init_cnt == INIT_LOAD) begin
      state_d.ctrl[THR_LSB +: 2] = state_q.sync2[SY_THR_SU +: 2];
      state_d.ctrl[AUX_LSB +: 2] = state_q.sync2[SY_AUX_SU +: 2];
    end else if (wr_ctrl) begin
      state_d.ctrl = i_wr_data[5:0];
    end

    if (wr_conv) begin
      state_d.reduce_en = i_wr_data[0];
    end
    // pin pulse wins over a software write in the same cycle
    if (!state_q.sync2[SY_PIN_N]) begin
      state_d.reduce_en = 1'b0;
    end

    // 3.3 V part ignores the field entirely
    thr_sel = state_q.sync2[SY_V3V3] ? 2'h0 : state_q.ctrl[THR_LSB +: 2];
    state_d.sys_rst = state_q.sync2[SY_MAIN + thr_sel];
    state_d.conv_5v = state_q.reduce_en && state_q.sync2[SY_OT];
    state_d.pass_en = !state_q.sync2[SY_EXT_OV];

    case (state_q.ctrl[AUX_LSB +: 2])
      2'h0: aux_mode_on = 1'b0;
      2'h1: aux_mode_on = (i_op_mode == MODE_NORMAL);
      2'h2: aux_mode_on = (i_op_mode == MODE_NORMAL) || (i_op_mode == MODE_STANDBY)
                          || (i_op_mode == MODE_RESET);
      default: aux_mode_on = 1'b1;
    endcase
    aux_fault = (state_q.ctrl[SHUT_LSB] && state_q.sync2[SY_BAT_UV])
                || (state_q.ctrl[SHUT_LSB+1] && state_q.sync2[SY_BAT_OV]);
    state_d.aux_en = aux_mode_on && !aux_fault;

    irq_event[IRQ_MAIN_UV]  = state_q.sync2[SY_MAIN];
    irq_event[IRQ_EXT_LOW]  = state_q.sync2[SY_EXT_LOW];
    irq_event[IRQ_EXT_HIGH] = state_q.sync2[SY_EXT_HIGH];
    irq_event[IRQ_OVERTEMP] = state_q.sync2[SY_OT];
    // a set arriving with its clear is kept
    state_d.irq_stat = (wr_irq ? (state_q.irq_stat & ~i_wr_data[3:0]) : state_q.irq_stat)
                       | irq_event;
    if (wr_mask) begin
      state_d.irq_mask = i_wr_data[3:0];
    end
    // only enabled sources reach the pin
    state_d.irq = |(state_d.irq_stat & state_d.irq_mask);

    status_rd = {state_q.conv_5v, state_q.aux_en, state_q.pass_en, state_q.sys_rst,
                 state_q.sync2[SY_OT],
                 state_q.sync2[SY_EXT_HIGH], state_q.sync2[SY_EXT_LOW],
                 state_q.sync2[SY_MAIN]};
    state_d.rd_data = 8'h00;
    if (i_rd_stb) begin
      case (i_addr)
        REG_CTRL_ADDR: state_d.rd_data = {2'h0, state_q.ctrl};
        REG_STAT_ADDR: state_d.rd_data = status_rd;
        REG_IRQ_ADDR:  state_d.rd_data = {4'h0, state_q.irq_stat};
        REG_MASK_ADDR: state_d.rd_data = {4'h0, state_q.irq_mask};
        REG_CONV_ADDR: state_d.rd_data = {7'h00, state_q.reduce_en};
        default:       state_d.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q.sync1     <= SYNC_RESET;
      state_q.sync2     <= SYNC_RESET;
      state_q.init_cnt  <= 2'h0;
      state_q.ctrl      <= CTRL_RESET;
      state_q.reduce_en <= 1'b0;
      state_q.irq_stat  <= IRQ_RESET;
      state_q.irq_mask  <= MASK_RESET;
      state_q.conv_5v   <= 1'b0;
      state_q.sys_rst   <= 1'b1;
      state_q.aux_en    <= 1'b0;
      state_q.pass_en   <= 1'b0;
      state_q.irq       <= 1'b0;
      state_q.rd_data   <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rd_data         = state_q.rd_data;
  assign o_conv_out_5v_sel = state_q.conv_5v;
  assign o_sys_reset       = state_q.sys_rst;
  assign o_aux_reg_en      = state_q.aux_en;
  assign o_ext_pass_en     = state_q.pass_en;
  assign o_irq             = state_q.irq;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  reduce_to_5v_a: assert property ((state_q.reduce_en && i_overtemp_warn && i_external_reset_pin_n)[*4]
    |-> o_conv_out_5v_sel) else $error("converter not reduced on overtemp");
  pin_clears_opt_a: assert property ((!i_external_reset_pin_n)[*3] |=> !state_q.reduce_en)
    else $error("reduction option survived pin pulse");
  // two sync stages plus the output flop: the output is seen one sample after the third
  low_v3v3_thr_a: assert property ((i_variant_3v3 && i_main_below_lvl[0])[*3] |=> o_sys_reset)
    else $error("3.3 V part missed 90 percent reset");
  no_reset_ok_a: assert property ((i_main_below_lvl == 4'h0)[*3] |=> !o_sys_reset)
    else $error("reset without undervoltage");
  thr_sixty_a: assert property ((!i_variant_3v3 && state_q.ctrl[1:0] == 2'h3
    && i_main_below_lvl == 4'h7)[*3] |=> !o_sys_reset)
    else $error("60 percent setting reset above its level");
  pass_off_ov_a: assert property (i_ext_overvoltage[*3] |=> !o_ext_pass_en)
    else $error("pass transistor on in overvoltage");
  pass_back_on_a: assert property ((!i_ext_overvoltage)[*3] |=> o_ext_pass_en)
    else $error("pass transistor not restored");
  aux_off_code_a: assert property (state_q.ctrl[3:2] == 2'h0 |=> !o_aux_reg_en)
    else $error("aux on with off code");
  aux_shut_uv_a: assert property ((state_q.ctrl[4] && i_bat_undervolt)[*3] |=> !o_aux_reg_en)
    else $error("aux kept on in battery undervoltage");
  main_irq_a: assert property ((i_main_below_lvl[0] && state_q.irq_mask[0])[*4] |=> o_irq)
    else $error("main undervoltage interrupt missing");
  rsvd_zero_a: assert property (i_rd_stb && i_addr == REG_CTRL_ADDR |=> o_rd_data[7:6] == 2'h0)
    else $error("reserved control bits not zero");
  ext_high_st_a: assert property (i_ext_above_110[*3] ##1 (i_rd_stb && i_addr == REG_STAT_ADDR)
    |=> o_rd_data[2]) else $error("high status not shown");

  cov_reduce_c: cover property ($rose(o_conv_out_5v_sel));
  cov_reset_c:  cover property ($rose(o_sys_reset) ##[1:20] $fell(o_sys_reset));
  cov_irq_c:    cover property ($rose(o_irq) ##[1:20] $fell(o_irq));
  cov_pass_c:   cover property ($fell(o_ext_pass_en));

endmodule
`default_nettype wire

// >>> verification/rsc_supply_model.sv
// Purpose: analog side of the supplies, turning percentages into comparator levels
// Assumes: percentages of nominal output, whole numbers
// Notes:   comparators are ideal, no hysteresis modelled
`timescale 1ns/100ps
`default_nettype none
module rsc_supply_model (
  input  wire logic [7:0] i_main_pct,
  input  wire logic [7:0] i_ext_pct,
  output logic      [3:0] o_main_below,
  output logic            o_ext_low,
  output logic            o_ext_high
);
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_main_below[k] = i_main_pct < 8'(90 - 10 * k);
    end
    o_ext_low  = i_ext_pct < 8'd90;
    o_ext_high = i_ext_pct >= 8'd110;
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench of the regulator supervision block
// Assumes: register reads compared from a queue one cycle after the strobe
// Notes:   waits of 6 cycles cover the 3-edge comparator path with margin
`timescale 1ns/100ps
`default_nettype none
module tb
  import rsc_pkg::*;
;
  logic i_ref_clk = 0, i_rst = 1, i_wr_stb = 0, i_rd_stb = 0, rd_q = 0;
  logic [7:0] i_addr = 0, i_wr_data = 0, o_rd_data, main_pct = 100, ext_pct = 100, ctrl_v;
  logic [3:0] below;
  logic ext_low, ext_high, ot = 0, ext_ov = 0, bat_uv = 0, bat_ov = 0, pin_n = 1, v3 = 0, red_v;
  logic o_conv, o_sysr, o_aux, o_pass, o_irq;
  rsc_mode_type mode = MODE_NORMAL;
  logic [7:0] exp_q[$];
  int error_cnt = 0, n_compared = 0;
  initial forever #5 i_ref_clk = ~i_ref_clk;
  rsc_supply_model sup_u (.i_main_pct(main_pct), .i_ext_pct(ext_pct), .o_main_below(below),
    .o_ext_low(ext_low), .o_ext_high(ext_high));
  rsc_regulator_supervision dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .i_main_below_lvl(below), .i_overtemp_warn(ot), .i_ext_below_90(ext_low),
    .i_ext_above_110(ext_high), .i_ext_overvoltage(ext_ov), .i_bat_undervolt(bat_uv),
    .i_bat_overvolt(bat_ov), .i_external_reset_pin_n(pin_n), .i_variant_3v3(v3),
    .i_main_threshold_startup_bits(2'h2), .i_aux_startup_bits(2'h1), .i_op_mode(mode),
    .o_conv_out_5v_sel(o_conv), .o_sys_reset(o_sysr), .o_aux_reg_en(o_aux),
    .o_ext_pass_en(o_pass), .o_irq(o_irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr_stb  <= 1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_stb  <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd_stb <= 1;
    i_addr   <= a;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd_stb <= 0;
  endtask
  // status layout: main90, ext low, ext high, overtemp, reset, pass, aux, 5 V
  function automatic logic [7:0] exp_stat();
    logic aux;
    aux = (ctrl_v[3:2] == 2'h3) || (ctrl_v[3:2] == 2'h1 && mode == MODE_NORMAL) ||
          (ctrl_v[3:2] == 2'h2 && mode inside {MODE_NORMAL, MODE_STANDBY, MODE_RESET});
    aux = aux & ~(ctrl_v[4] & bat_uv) & ~(ctrl_v[5] & bat_ov);
    return {red_v & ot, aux, ~ext_ov, main_pct < (v3 ? 8'd90 : 8'd90 - 8'd10 * ctrl_v[1:0]),
            ot, ext_pct >= 8'd110, ext_pct < 8'd90, main_pct < 8'd90};
  endfunction
  always @(posedge i_ref_clk) rd_q <= i_rd_stb;
  always @(negedge i_ref_clk) begin
    if (rd_q && exp_q.size() > 0) begin
      check(o_rd_data, exp_q.pop_front(), "read data");
    end
  end
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(32'ha7ec));
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 0;
    repeat (4) @(posedge i_ref_clk);
    rd(REG_CTRL_ADDR, 8'h06);
    rd(REG_CONV_ADDR, 8'h00);
    wr(REG_CTRL_ADDR, 8'hff);
    rd(REG_CTRL_ADDR, 8'h3f);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 80; i++) begin
      @(posedge i_ref_clk);
      main_pct <= 8'($urandom_range(100, 50));
      ext_pct  <= 8'($urandom_range(120, 80));
      {ot, ext_ov, bat_uv, bat_ov, v3} <= 5'($urandom);
      mode     <= rsc_mode_type'($urandom % 5);
      ctrl_v = 8'($urandom);
      red_v  = 1'($urandom);
      wr(REG_CTRL_ADDR, ctrl_v);
      ctrl_v = ctrl_v & 8'h3f;
      wr(REG_CONV_ADDR, {7'h0, red_v});
      repeat (6) @(posedge i_ref_clk);
      #1 check({4'h0, o_conv, o_aux, o_pass, o_sysr}, exp_stat() >> 4, "output pins");
      rd(REG_CTRL_ADDR, ctrl_v);
      rd(REG_STAT_ADDR, exp_stat());
    end
    @(posedge i_ref_clk);
    {main_pct, ext_pct, ot} <= {8'd100, 8'd100, 1'b0};
    repeat (6) @(posedge i_ref_clk);
    wr(REG_MASK_ADDR, 8'h00);
    wr(REG_IRQ_ADDR, 8'h0f);
    rd(REG_IRQ_ADDR, 8'h00);
    {main_pct, ext_pct, ot} <= {8'd85, 8'd115, 1'b1};
    repeat (6) @(posedge i_ref_clk);
    rd(REG_IRQ_ADDR, 8'h0d);
    #1 check({7'h0, o_irq}, 8'h00, "irq while enable off");
    wr(REG_MASK_ADDR, 8'h01);
    repeat (3) @(posedge i_ref_clk);
    #1 check({7'h0, o_irq}, 8'h01, "irq with enable on");
    {main_pct, ext_pct, ot} <= {8'd100, 8'd80, 1'b0};
    repeat (6) @(posedge i_ref_clk);
    wr(REG_IRQ_ADDR, 8'h0f);
    rd(REG_IRQ_ADDR, 8'h02);
    repeat (3) @(posedge i_ref_clk);
    #1 check({7'h0, o_irq}, 8'h00, "irq after clear");
    wr(REG_CONV_ADDR, 8'h01);
    rd(REG_CONV_ADDR, 8'h01);
    pin_n <= 0;
    @(posedge i_ref_clk);
    pin_n <= 1;
    repeat (6) @(posedge i_ref_clk);
    rd(REG_CONV_ADDR, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    final_report();
  end
endmodule
`default_nettype wire
